// File: gate_consts.svh
// Constants for the playback noise gate: offsets, fields, timing
`ifndef GATE_CONSTS_SVH
`define GATE_CONSTS_SVH

// ********************************
// Register offsets
// ********************************
`define ADDR_GATE_CONTROL       8'h9c
`define ADDR_GATE_TIMING        8'h9d
`define ADDR_GATE_RELEASE_LEVEL 8'h9e
`define ADDR_GATE_ENGAGE_LEVEL  8'h9f
`define ADDR_GATE_STATUS        8'ha0

// ********************************
// Field positions and reset values
// ********************************
`define GATE_ENABLE_BIT     7
`define MUTE_RAMP_BIT       3
`define UNMUTE_RAMP_BIT     2
`define HOLD_MSB            1
`define HOLD_LSB            0
`define THRESH_MSB          2
`define THRESH_LSB          0
`define STAT_GATED_BIT      0
`define STAT_MUTED_BIT      1
`define STAT_OPEN_BIT       2
`define REG_RESET           8'h00

// ********************************
// Levels and gain
// ********************************
`define HOLD_BASE_SAMPLES   12'd256
`define THRESH_BASE_LEVEL   24'd67
`define GAIN_FRAC_BITS      8
`define DB_PER_SHIFT        3'd5
`define MUTE_SHIFT          5'd24

// ********************************
// Timing
// ********************************
`define CLK_PERIOD_NS       8
`define CLK_HZ              125000000
`define MUTE_FAST_NS        880000
`define MUTE_SLOW_NS        14080000
`define UNMUTE_SLOW_NS      220000
`define UNMUTE_FAST_NS      13800
`define RATE_8K_HZ          8000
`define RATE_11K_HZ         11025
`define RATE_12K_HZ         12000
`define RATE_16K_HZ         16000
`define RATE_22K_HZ         22050
`define RATE_24K_HZ         24000
`define RATE_32K_HZ         32000
`define RATE_44K_HZ         44100
`define RATE_48K_HZ         48000
`define RATE_88K_HZ         88200
`define RATE_96K_HZ         96000

`endif

// File: gate_pkg.sv
// Types shared by the playback noise gate modules
package gate_pkg;
  localparam int CHANNELS = 2;
  localparam int SAMPLE_W = 24;

  typedef logic signed [SAMPLE_W-1:0] sample_t;

  typedef struct packed {
    logic                     valid;
    sample_t [CHANNELS-1:0]   ch;
  } frame_s;

  typedef struct packed {
    logic [4:0] shift;
    logic [2:0] frac;
  } atten_s;

  typedef enum logic [1:0] {
    ST_OPEN  = 2'b01,
    ST_GATED = 2'b10
  } gate_state_e;
endpackage

// File: gate_level_detect.sv
// Largest magnitude across all playback channels of each frame
module gate_level_detect (
  input  wire logic                          clk_sys_i,
  input  wire logic                          sys_rst_i,
  input  wire gate_pkg::frame_s              frame_i,
  output logic [gate_pkg::SAMPLE_W-1:0]      peak_o,
  output logic                               peak_vld_o
);
  import gate_pkg::*;

  logic [SAMPLE_W-1:0] mag [CHANNELS];
  logic [SAMPLE_W-1:0] peak_d;
  logic [SAMPLE_W-1:0] peak_q;
  logic                vld_q;

  // ********************************
  // Magnitudes
  // ********************************
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_mag
      // Most negative code saturates instead of wrapping back to itself
      always_comb begin
        if (frame_i.ch[g] == {1'b1, {(SAMPLE_W-1){1'b0}}}) begin
          mag[g] = {1'b0, {(SAMPLE_W-1){1'b1}}};
        end else if (frame_i.ch[g][SAMPLE_W-1]) begin
          mag[g] = SAMPLE_W'(-frame_i.ch[g]);
        end else begin
          mag[g] = frame_i.ch[g];
        end
      end
    end
  endgenerate

  always_comb begin
    peak_d = peak_q;
    if (frame_i.valid) begin
      peak_d = '0;
      for (int i = 0; i < CHANNELS; i++) begin
        if (mag[i] > peak_d) begin
          peak_d = mag[i];
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      peak_q <= '0;
      vld_q  <= 1'b0;
    end else begin
      peak_q <= peak_d;
      vld_q  <= frame_i.valid;
    end
  end

  assign peak_o     = peak_q;
  assign peak_vld_o = vld_q;
endmodule

// File: gate_gain_ramp.sv
// Attenuation stepper: 1 dB per step toward mute or toward unity
`include "gate_consts.svh"
module gate_gain_ramp #(
  parameter int unsigned MUTE_FAST   = `MUTE_FAST_NS / `CLK_PERIOD_NS,
  parameter int unsigned MUTE_SLOW   = `MUTE_SLOW_NS / `CLK_PERIOD_NS,
  parameter int unsigned UNMUTE_SLOW = `UNMUTE_SLOW_NS / `CLK_PERIOD_NS,
  parameter int unsigned UNMUTE_FAST = `UNMUTE_FAST_NS / `CLK_PERIOD_NS
) (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic              enable_i,
  input  wire logic              close_i,
  input  wire logic              mute_slow_i,
  input  wire logic              unmute_fast_i,
  output gate_pkg::atten_s       atten_o,
  output logic                   muted_o,
  output logic                   open_o
);
  import gate_pkg::*;

  atten_s      atten_d;
  atten_s      atten_q;
  logic [23:0] timer_d;
  logic [23:0] timer_q;
  logic [23:0] step_len;
  logic        at_mute;
  logic        at_unity;

  assign at_mute  = (atten_q.shift == `MUTE_SHIFT);
  assign at_unity = (atten_q == '0);

  always_comb begin
    if (close_i) begin
      step_len = mute_slow_i ? 24'(MUTE_SLOW) : 24'(MUTE_FAST); // [RULE5]
    end else begin
      step_len = unmute_fast_i ? 24'(UNMUTE_FAST)
                               : 24'(UNMUTE_SLOW); // [RULE6]
    end
  end

  always_comb begin
    atten_d = atten_q;
    timer_d = timer_q;
    if (!enable_i) begin
      atten_d = '0; // [RULE1]
      timer_d = '0;
    end else if ((close_i && at_mute) || (!close_i && at_unity)) begin
      timer_d = '0;
    end else if (timer_q + 24'd1 >= step_len) begin
      timer_d = '0;
      if (close_i) begin
        // One dB down; six steps make one halving
        if (atten_q.frac == `DB_PER_SHIFT) begin
          atten_d.frac  = '0;
          atten_d.shift = atten_q.shift + 5'd1;
        end else begin
          atten_d.frac = atten_q.frac + 3'd1;
        end // [RULE5]
      end else begin
        if (atten_q.frac == '0) begin
          atten_d.frac  = `DB_PER_SHIFT;
          atten_d.shift = atten_q.shift - 5'd1;
        end else begin
          atten_d.frac = atten_q.frac - 3'd1;
        end // [RULE6]
      end
    end else begin
      timer_d = timer_q + 24'd1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      atten_q <= '0;
      timer_q <= '0;
    end else begin
      atten_q <= atten_d;
      timer_q <= timer_d;
    end
  end

  assign atten_o = atten_q;
  assign muted_o = at_mute;
  assign open_o  = at_unity;
endmodule

// File: playback_noise_gate.sv
// Playback noise gate: register file, quiet counter, gain stage
//
// Function
// RULE1: Gate acts only while control bit 7 is set; reset leaves it off.
// RULE2: Mute after peak stays below engage level for 256..2048 samples.
// RULE3: Engage level code 0..7 maps -102 dB to -60 dB, 6 dB steps.
// RULE4: Release when peak rises above release level, same encoding.
// RULE5: Mute ramp 0.88 ms/dB, or 14.08 ms/dB when timing bit 3 set.
// RULE6: Unmute ramp 0.22 ms/dB, or 0.0138 ms/dB when timing bit 2 set.
// RULE7: Quiet samples are counted at the selected playback sample rate.
// RULE8: Any sample at or above engage level restarts the quiet count.
`include "gate_consts.svh"
module playback_noise_gate #(
  parameter int unsigned CLK_HZ      = `CLK_HZ,
  parameter int unsigned MUTE_FAST   = `MUTE_FAST_NS / `CLK_PERIOD_NS,
  parameter int unsigned MUTE_SLOW   = `MUTE_SLOW_NS / `CLK_PERIOD_NS,
  parameter int unsigned UNMUTE_SLOW = `UNMUTE_SLOW_NS / `CLK_PERIOD_NS,
  parameter int unsigned UNMUTE_FAST = `UNMUTE_FAST_NS / `CLK_PERIOD_NS,
  parameter int          DIV_W       = 16
) (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic [7:0]             reg_rdata_o,
  input  wire logic [3:0]        playback_rate_select_i,
  input  wire gate_pkg::frame_s  frame_i,
  output gate_pkg::frame_s       frame_o,
  output logic                   gated_o
);
  import gate_pkg::*;

  // ********************************
  // Helpers
  // ********************************
  // Unlisted rate codes fall back to 44.1 kHz pacing
  function automatic logic [DIV_W-1:0] sample_div(input logic [3:0] code);
    int unsigned hz;
    hz = `RATE_44K_HZ;
    case (code)
      4'h1: hz = `RATE_8K_HZ;
      4'h2: hz = `RATE_11K_HZ;
      4'h3: hz = `RATE_12K_HZ;
      4'h5: hz = `RATE_16K_HZ;
      4'h6: hz = `RATE_22K_HZ;
      4'h7: hz = `RATE_24K_HZ;
      4'h9: hz = `RATE_32K_HZ;
      4'ha: hz = `RATE_44K_HZ;
      4'hb: hz = `RATE_48K_HZ;
      4'he: hz = `RATE_88K_HZ;
      4'hf: hz = `RATE_96K_HZ;
      default: hz = `RATE_44K_HZ;
    endcase
    return DIV_W'(CLK_HZ / hz);
  endfunction

  // 6 dB is taken as one doubling; error stays under 0.2 dB per step
  function automatic logic [SAMPLE_W-1:0] level_of(input logic [2:0] code);
    return `THRESH_BASE_LEVEL << code;
  endfunction

  // Fractional dB gain in Q8, 0 to 5 dB
  function automatic logic [8:0] db_gain(input logic [2:0] frac);
    logic [8:0] g;
    g = 9'h100;
    case (frac)
      3'h1: g = 9'h0e4;
      3'h2: g = 9'h0cb;
      3'h3: g = 9'h0b5;
      3'h4: g = 9'h0a1;
      3'h5: g = 9'h090;
      default: g = 9'h100;
    endcase
    return g;
  endfunction

  // ********************************
  // Register file
  // ********************************
  logic [7:0]  control_q, control_d;
  logic [7:0]  timing_q, timing_d;
  logic [7:0]  release_q, release_d;
  logic [7:0]  engage_q, engage_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        gate_enable;
  logic        mute_ramp_speed;
  logic        unmute_ramp_speed;
  logic [1:0]  quiet_hold_length;
  logic [2:0]  engage_threshold;
  logic [2:0]  release_threshold;
  logic        ramp_muted;
  logic        ramp_open;
  gate_state_e state_q, state_d;

  assign gate_enable       = control_q[`GATE_ENABLE_BIT];
  assign mute_ramp_speed   = timing_q[`MUTE_RAMP_BIT];
  assign unmute_ramp_speed = timing_q[`UNMUTE_RAMP_BIT];
  assign quiet_hold_length = timing_q[`HOLD_MSB:`HOLD_LSB];
  assign engage_threshold  = engage_q[`THRESH_MSB:`THRESH_LSB];
  assign release_threshold = release_q[`THRESH_MSB:`THRESH_LSB];

  always_comb begin
    control_d = control_q;
    timing_d  = timing_q;
    release_d = release_q;
    engage_d  = engage_q;
    rdata_d   = '0;
    if (reg_wr_i) begin
      // Reserved bits are not stored and read back as zero
      unique case (reg_addr_i)
        `ADDR_GATE_CONTROL:
          control_d = reg_wdata_i & 8'h80;
        `ADDR_GATE_TIMING:
          timing_d = reg_wdata_i & 8'h0f;
        `ADDR_GATE_RELEASE_LEVEL:
          release_d = reg_wdata_i & 8'h07;
        `ADDR_GATE_ENGAGE_LEVEL:
          engage_d = reg_wdata_i & 8'h07;
        default: ;
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `ADDR_GATE_CONTROL:       rdata_d = control_q;
        `ADDR_GATE_TIMING:        rdata_d = timing_q;
        `ADDR_GATE_RELEASE_LEVEL: rdata_d = release_q;
        `ADDR_GATE_ENGAGE_LEVEL:  rdata_d = engage_q;
        `ADDR_GATE_STATUS: begin
          rdata_d[`STAT_GATED_BIT] = (state_q == ST_GATED);
          rdata_d[`STAT_MUTED_BIT] = ramp_muted;
          rdata_d[`STAT_OPEN_BIT]  = ramp_open;
        end
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      control_q <= `REG_RESET;
      timing_q  <= `REG_RESET;
      release_q <= `REG_RESET;
      engage_q  <= `REG_RESET;
      rdata_q   <= '0;
    end else begin
      control_q <= control_d;
      timing_q  <= timing_d;
      release_q <= release_d;
      engage_q  <= engage_d;
      rdata_q   <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ********************************
  // Level detection and sample pacing
  // ********************************
  logic [SAMPLE_W-1:0] peak;
  logic                peak_vld;
  logic [DIV_W-1:0]    div_q, div_d;
  logic                tick;
  logic                loud;
  logic                quiet;
  logic                above_release;

  gate_level_detect u_level (
    .clk_sys_i  (clk_sys_i),
    .sys_rst_i  (sys_rst_i),
    .frame_i    (frame_i),
    .peak_o     (peak),
    .peak_vld_o (peak_vld)
  );

  assign loud          = peak >= level_of(engage_threshold); // [RULE3]
  assign quiet         = !loud;
  assign above_release = peak > level_of(release_threshold); // [RULE4]

  // Pacing from the rate field keeps hold times within one tick even if frames stall
  always_comb begin
    div_d = div_q + DIV_W'(1);
    tick  = 1'b0;
    if (div_q + DIV_W'(1) >= sample_div(playback_rate_select_i)) begin
      div_d = '0;
      tick  = 1'b1;
    end // [RULE7]
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  // ********************************
  // Gate state machine
  // ********************************
  logic [11:0] quiet_q, quiet_d;
  logic [11:0] hold_target;

  assign hold_target = `HOLD_BASE_SAMPLES << quiet_hold_length; // [RULE2]

  always_comb begin
    state_d = state_q;
    quiet_d = quiet_q;
    if (!gate_enable) begin
      state_d = ST_OPEN; // [RULE1]
      quiet_d = '0;
    end else begin
      unique case (state_q)
        ST_OPEN: begin
          if (peak_vld && loud) begin
            quiet_d = '0; // [RULE8]
          end else if (tick && quiet) begin
            if (quiet_q + 12'd1 >= hold_target) begin
              state_d = ST_GATED; // [RULE2]
              quiet_d = '0;
            end else begin
              quiet_d = quiet_q + 12'd1;
            end
          end
        end
        ST_GATED: begin
          if (above_release) begin
            state_d = ST_OPEN; // [RULE4]
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ST_OPEN;
      quiet_q <= '0;
    end else begin
      state_q <= state_d;
      quiet_q <= quiet_d;
    end
  end

  assign gated_o = (state_q == ST_GATED);

  // ********************************
  // Gain ramp and output stage
  // ********************************
  atten_s atten;

  gate_gain_ramp #(
    .MUTE_FAST   (MUTE_FAST),
    .MUTE_SLOW   (MUTE_SLOW),
    .UNMUTE_SLOW (UNMUTE_SLOW),
    .UNMUTE_FAST (UNMUTE_FAST)
  ) u_ramp (
    .clk_sys_i     (clk_sys_i),
    .sys_rst_i     (sys_rst_i),
    .enable_i      (gate_enable),
    .close_i       (state_q == ST_GATED),
    .mute_slow_i   (mute_ramp_speed),
    .unmute_fast_i (unmute_ramp_speed),
    .atten_o       (atten),
    .muted_o       (ramp_muted),
    .open_o        (ramp_open)
  );

  frame_s frame_q, frame_d;

  always_comb begin
    logic signed [SAMPLE_W+9:0] prod;
    prod    = '0;
    frame_d = frame_i;
    if (gate_enable) begin
      for (int i = 0; i < CHANNELS; i++) begin
        prod = frame_i.ch[i] * $signed({1'b0, db_gain(atten.frac)});
        prod = prod >>> `GAIN_FRAC_BITS;
        prod = prod >>> atten.shift;
        // Full attenuation forces hard zero, no residual LSB noise
        frame_d.ch[i] = ramp_muted ? '0 : prod[SAMPLE_W-1:0]; // [RULE2]
      end
    end // [RULE1]
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      frame_q <= '0;
    end else begin
      frame_q <= frame_d;
    end
  end

  assign frame_o = frame_q;
endmodule

// File: frame_source.sv
// Sample source standing in for the playback filter path
module frame_source #(
  parameter int PERIOD = 4
) (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire gate_pkg::sample_t amp_i,
  output gate_pkg::frame_s       frame_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import gate_pkg::*;
  int cnt_q;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q   <= 0;
      frame_o <= '0;
    end else begin
      cnt_q         <= (cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
      frame_o.valid <= (cnt_q == 0);
      // Junk between frames so a stale sample never looks valid
      frame_o.ch[0] <= (cnt_q == 0) ? amp_i : ~frame_o.ch[0];
      frame_o.ch[1] <= (cnt_q == 0) ? -amp_i : ~frame_o.ch[1];
    end
  end
endmodule

// File: playback_noise_gate_sva.sv
// Port-level assertions for the playback noise gate
module playback_noise_gate_sva #(
  parameter int unsigned CLK_HZ = 125000000
) (
  input wire logic             clk_sys_i,
  input wire logic             sys_rst_i,
  input wire logic [7:0]       reg_addr_i,
  input wire logic [7:0]       reg_wdata_i,
  input wire logic             reg_wr_i,
  input wire logic             reg_rd_i,
  input wire logic [7:0]       reg_rdata_o,
  input wire logic [3:0]       playback_rate_select_i,
  input wire gate_pkg::frame_s frame_i,
  input wire gate_pkg::frame_s frame_o,
  input wire logic             gated_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import gate_pkg::*;
  // First tick may come early, so allow one tick short of 256
  localparam int MIN_QUIET = 255 * (CLK_HZ / 96000);
  logic        en_q;
  logic        en_d;
  logic [19:0] quiet_q;
  logic [19:0] quiet_d;
  logic        loud;
  // Above every release and engage level
  assign loud = frame_i.valid &&
                (frame_i.ch[0] > 24'sd8576 || frame_i.ch[0] < -24'sd8576);
  always_comb begin
    en_d    = (reg_wr_i && reg_addr_i == 8'h9c) ? reg_wdata_i[7] : en_q;
    quiet_d = (!en_q || loud) ? '0 :
              ((quiet_q == '1) ? quiet_q : quiet_q + 20'h1);
  end
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      en_q    <= 1'b0;
      quiet_q <= '0;
    end else begin
      en_q    <= en_d;
      quiet_q <= quiet_d;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_loud_open;
    loud && !gated_o;
  endsequence
  sequence s_stays_open;
    !gated_o [*8];
  endsequence
  a_ctrl_readback: assert property (
    reg_rd_i && reg_addr_i == 8'h9c |=> reg_rdata_o == {en_q, 7'h00})
    else $error("control read data wrong");
  a_bypass_exact: assert property (
    !en_q && frame_i.valid |=> frame_o.ch == $past(frame_i.ch))
    else $error("disabled gate altered samples");
  a_disabled_open: assert property (
    !en_q [*2] |-> !gated_o)
    else $error("gate closed while disabled");
  a_frame_delay: assert property (
    frame_i.valid |=> frame_o.valid)
    else $error("frame lost in pipeline");
  a_rise_enabled: assert property (
    $rose(gated_o) |-> en_q)
    else $error("gate closed without enable");
  a_quiet_length: assert property (
    $rose(gated_o) |-> quiet_q >= MIN_QUIET)
    else $error("gate closed too early");
  a_loud_release: assert property (
    gated_o && loud |-> ##[1:3] !gated_o)
    else $error("gate not released on loud frame");
  a_loud_restart: assert property (
    s_loud_open |-> ##4 s_stays_open)
    else $error("gate closed right after loud frame");
endmodule
bind playback_noise_gate playback_noise_gate_sva #(.CLK_HZ(CLK_HZ)) sva_i (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .frame_i(frame_i), .frame_o(frame_o),
  .playback_rate_select_i(playback_rate_select_i), .gated_o(gated_o));

// File: test_playback_noise_gate.sv
// Self-checking bench for the playback noise gate
module test_playback_noise_gate;
  timeunit 1ns;
  timeprecision 1ps;
  import gate_pkg::*;
  logic        clk_sys_i;
  logic        sys_rst_i;
  logic [7:0]  reg_addr_i;
  logic [7:0]  reg_wdata_i;
  logic        reg_wr_i;
  logic        reg_rd_i;
  logic [7:0]  reg_rdata_o;
  logic [3:0]  rate;
  frame_s      frame_i;
  frame_s      frame_o;
  logic        gated_o;
  sample_t     amp;
  int          compares;
  int          miscompares;
  int          cycles;
  logic [7:0]  masks [4] = '{8'h80, 8'h0f, 8'h07, 8'h07};
  // Small clock rate: 96 kHz tick every 8 cycles
  playback_noise_gate #(.CLK_HZ(800000), .MUTE_FAST(20), .MUTE_SLOW(40),
    .UNMUTE_SLOW(10), .UNMUTE_FAST(5)) playback_noise_gate_i (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .playback_rate_select_i(rate),
    .frame_i(frame_i), .frame_o(frame_o), .gated_o(gated_o));
  frame_source frame_source_i (.clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i), .amp_i(amp), .frame_o(frame_i));
  // ********************************
  // Shared tasks
  // ********************************
  task automatic give_verdict;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  task automatic wait_frame;
    // Leave the launching edge before looking at the output
    @(negedge clk_sys_i);
    for (int i = 0; i < 16 && frame_o.valid !== 1'b1; i++) begin
      @(negedge clk_sys_i);
    end
  endtask
  task automatic wait_gated(input logic lvl, input int lim);
    for (int i = 0; i < lim && gated_o !== lvl; i++) begin
      @(posedge clk_sys_i);
    end
    #1 chk(gated_o, lvl);
  endtask
  // ********************************
  // Scenarios
  // ********************************
  task automatic t_regs;
    logic [7:0] d;
    rd(8'ha0, d);
    chk(d, 8'h04);
    for (int i = 0; i < 4; i++) begin
      rd(8'h9c + 8'(i), d);
      chk(d, 8'h00);
      wr(8'h9c + 8'(i), 8'hff);
      rd(8'h9c + 8'(i), d);
      chk(d, masks[i]);
      wr(8'h9c + 8'(i), 8'h00);
    end
    rd(8'ha5, d);
    chk(d, 8'h00);
  endtask
  task automatic t_bypass;
    repeat (2600) @(posedge clk_sys_i);
    chk(gated_o, 1'b0);
    wait_frame();
    chk(frame_o.ch[0], amp);
    chk({8'h00, frame_o.ch[1]}, {8'h00, -amp});
  endtask
  task automatic t_gate;
    logic [7:0] d;
    wr(8'h9c, 8'h80);
    repeat (1600) @(posedge clk_sys_i);
    amp <= 24'sd100000;
    repeat (8) @(posedge clk_sys_i);
    amp <= 24'sd10;
    repeat (1600) @(posedge clk_sys_i);
    chk(gated_o, 1'b0);
    wait_gated(1'b1, 600);
    repeat (3200) @(posedge clk_sys_i);
    wait_frame();
    chk(frame_o.ch[0], 32'h0);
    rd(8'ha0, d);
    chk(d, 8'h03);
    wr(8'h9e, 8'h07);
    amp <= 24'sd8000;
    repeat (200) @(posedge clk_sys_i);
    chk(gated_o, 1'b1);
    amp <= 24'sd9000;
    wait_gated(1'b0, 20);
    repeat (1600) @(posedge clk_sys_i);
    wait_frame();
    chk(frame_o.ch[0], 32'd9000);
    // Slow mute: at 60 dB down the sample must still show
    wr(8'h9d, 8'h08);
    wr(8'h9f, 8'h07);
    amp <= 24'sd8000;
    wait_gated(1'b1, 2600);
    repeat (2400) @(posedge clk_sys_i);
    wait_frame();
    chk(frame_o.ch[0] != 24'sd0, 1'b1);
    // Fast unmute must reach unity well inside the slow ramp time
    wr(8'h9d, 8'h04);
    amp <= 24'sd9000;
    wait_gated(1'b0, 20);
    repeat (400) @(posedge clk_sys_i);
    wait_frame();
    chk(frame_o.ch[0], 32'd9000);
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    sys_rst_i   = 1'b1;
    reg_addr_i  = 8'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i    = 1'b0;
    reg_rd_i    = 1'b0;
    rate        = 4'hf;
    amp         = 24'sd10;
    compares    = 0;
    miscompares = 0;
    cycles      = 0;
    repeat (20) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_bypass();
    t_gate();
    give_verdict();
  end
endmodule
